// ==== include/fevt_pkg.sv ====
package fevt_pkg;

    // Register map, byte addresses
    localparam int unsigned      ADDR_W       = 12;
    localparam logic [11:0]      OFF_CAP      = 12'h008;
    localparam logic [11:0]      OFF_CTRL     = 12'h038;
    localparam logic [11:0]      OFF_DATA     = 12'h03c;
    localparam logic [11:0]      OFF_ADDR_LO  = 12'h040;
    localparam logic [11:0]      OFF_ADDR_HI  = 12'h044;
    localparam logic [11:0]      OFF_STAT     = 12'h048;
    localparam logic [11:0]      OFF_LOG_BASE = 12'h200;

    // Fault log geometry: one 16-byte slot per entry
    localparam int unsigned      LOG_N        = 4;
    localparam int unsigned      LOG_IW       = $clog2(LOG_N);
    localparam logic [11:0]      LOG_STRIDE   = 12'h010;
    localparam logic [11:0]      OFF_LOG_END  =
        OFF_LOG_BASE + 12'(LOG_N * LOG_STRIDE);

    // Reset values
    localparam logic [31:0]      ADDR_LO_RST  = 32'h0000_0000;
    localparam logic [31:0]      ADDR_HI_RST  = 32'h0000_0000;
    localparam logic [15:0]      DATA_RST     = 16'h0000;
    localparam logic             MASK_RST     = 1'b1;
    localparam logic             LOG_EN_RST   = 1'b0;

    // Field positions
    localparam int unsigned      CTRL_MASK_BIT  = 31;
    localparam int unsigned      CTRL_LOG_BIT   = 0;
    localparam int unsigned      STAT_PEND_BIT  = 0;
    localparam int unsigned      STAT_OVF_BIT   = 1;
    localparam int unsigned      STAT_LOG_BIT   = 2;
    localparam int unsigned      CAP_CNT_LSB    = 0;
    localparam int unsigned      CAP_OFF_LSB    = 16;
    localparam logic [1:0]       FLAG_WORD      = 2'h3;
    localparam int unsigned      FLAG_POS       = 31;

    // One 128-bit fault log entry, most significant field first
    typedef struct packed {
        logic        flag;
        logic        req_read;
        logic [1:0]  addr_kind;
        logic [19:0] pasid_value;
        logic [7:0]  reason_code;
        logic        prefix_present;
        logic        run_permission_asked;
        logic        supervisor_asked;
        logic        request_type_high;
        logic [11:0] rsvd;
        logic [15:0] source_id;
        logic [63:0] fault_info;
    } fevt_rec_s;

    // A fault reported by the translation logic
    typedef struct packed {
        logic        valid;
        logic [15:0] source_id;
        logic        req_read;
        logic [1:0]  addr_kind;
        logic [19:0] pasid_value;
        logic [7:0]  reason_code;
        logic        prefix_present;
        logic        run_permission_asked;
        logic        supervisor_asked;
    } fevt_fault_s;

    // Interrupt message write
    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] data;
    } fevt_msg_s;
endpackage

// ==== rtl/fevt_log_slot.sv ====
module fevt_log_slot import fevt_pkg::*; #(
    parameter bit HAS_DEV_TLB = 1'b1,
    parameter bit HAS_PASID   = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire fevt_fault_s fault,
    input  wire logic        clear_req,
    output fevt_rec_s        entry,
    output logic             logged,
    output logic             busy
);
    fevt_rec_s rec;
    fevt_rec_s next_rec;
    logic      arm;

    // Capture; unsupported features fold to zero here
    always_comb begin
        next_rec = rec;
        if (load) begin
            next_rec = '0;
            next_rec.source_id = fault.source_id;
            next_rec.req_read  = fault.req_read;
            next_rec.addr_kind =
                HAS_DEV_TLB ? fault.addr_kind : 2'h0;
            next_rec.reason_code = fault.reason_code;
            if (HAS_PASID) begin
                next_rec.pasid_value    = fault.pasid_value;
                next_rec.prefix_present = fault.prefix_present;
                next_rec.run_permission_asked =
                    fault.run_permission_asked;
                next_rec.supervisor_asked =
                    fault.supervisor_asked;
            end
        end
    end

    // Flag follows fields by one cycle; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec    <= '0;
            arm    <= 1'b0;
            logged <= 1'b0;
        end else begin
            rec    <= next_rec;
            arm    <= load;
            logged <= arm | (logged & ~clear_req);
        end
    end

    assign busy = arm | logged;

    always_comb begin
        entry      = rec;
        entry.flag = logged;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    flag_after_fields_a: assert property (
        load |=> !logged ##1 logged)
        else $error("flag not set one cycle after capture");
    fields_held_a: assert property (
        logged |=> $stable(rec) || !$past(logged))
        else $error("captured fields changed while logged");
    no_pasid_zero_a: assert property (
        !HAS_PASID |-> rec.pasid_value == 20'h0 && !rec.prefix_present)
        else $error("pasid fields nonzero without support");
endmodule // fevt_log_slot

// ==== rtl/fevt_regs.sv ====
// Local design decision: the APB register port.
module fevt_regs import fevt_pkg::*; #(
    parameter bit HAS_EXT_IRQ = 1'b1,
    parameter bit HAS_DEV_TLB = 1'b1,
    parameter bit HAS_PASID   = 1'b1
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire fevt_fault_s       fault,
    output logic                   fault_merged,
    output logic                   fault_dropped,
    output logic                   msg_valid,
    input  wire logic              msg_ready,
    output fevt_msg_s              msg
);
    // Software-visible state
    logic [31:0]      irq_addr_low;
    logic [31:0]      irq_addr_high;
    logic [15:0]      msg_data;
    logic             msg_mask;
    logic             log_en;
    logic             pending;
    logic             overflow;

    // Fault log slots
    fevt_rec_s        entry [LOG_N];
    logic [LOG_N-1:0] logged;
    logic [LOG_N-1:0] busy;
    logic [LOG_N-1:0] hit;
    logic [LOG_N-1:0] free;
    logic [LOG_N-1:0] load;
    logic [LOG_N-1:0] clear_req;

    // APB phases
    wire logic apb_setup = psel & ~penable;
    wire logic apb_acc   = psel & penable;
    wire logic apb_wr    = apb_acc & pwrite;

    // Address decode; misaligned addresses hit nothing
    wire logic aligned  = (paddr[1:0] == 2'h0);
    wire logic sel_cap  = aligned & (paddr == OFF_CAP);
    wire logic sel_ctrl = aligned & (paddr == OFF_CTRL);
    wire logic sel_data = aligned & (paddr == OFF_DATA);
    wire logic sel_lo   = aligned & (paddr == OFF_ADDR_LO);
    wire logic sel_hi   = aligned & (paddr == OFF_ADDR_HI);
    wire logic sel_stat = aligned & (paddr == OFF_STAT);
    wire logic sel_log  = aligned & (paddr >= OFF_LOG_BASE)
                        & (paddr < OFF_LOG_END);
    wire logic mapped   = sel_cap | sel_ctrl | sel_data | sel_lo
                        | sel_hi | sel_stat | sel_log;

    // Entry and word within the log window
    wire logic [ADDR_W-1:0] log_off  = paddr - OFF_LOG_BASE;
    wire logic [LOG_IW-1:0] log_idx  = log_off[LOG_IW+3:4];
    wire logic [1:0]        log_word = log_off[3:2];

    // Write strobes, taken at the access edge
    wire logic wr_ctrl = apb_wr & sel_ctrl;
    wire logic wr_data = apb_wr & sel_data;
    wire logic wr_lo   = apb_wr & sel_lo;
    wire logic wr_hi   = apb_wr & sel_hi;
    wire logic wr_stat = apb_wr & sel_stat;
    wire logic wr_log  = apb_wr & sel_log;

    // Zero wait states; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~mapped;

    // Message address, low part keeps dword alignment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_addr_low <= ADDR_LO_RST;
        end else if (wr_lo) begin
            irq_addr_low <= {pwdata[31:2], 2'h0};
        end
    end

    // Upper part exists only with extended interrupt mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_addr_high <= ADDR_HI_RST;
        end else if (wr_hi && HAS_EXT_IRQ) begin
            irq_addr_high <= pwdata;
        end
    end

    // Message data for the interrupt write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_data <= DATA_RST;
        end else if (wr_data) begin
            msg_data <= pwdata[15:0];
        end
    end

    // Mask and logging enable; mask is set out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_mask <= MASK_RST;
            log_en   <= LOG_EN_RST;
        end else if (wr_ctrl) begin
            msg_mask <= pwdata[CTRL_MASK_BIT];
            log_en   <= pwdata[CTRL_LOG_BIT];
        end
    end

    // Capture: merge on a same-source hit, else lowest free slot
    wire logic take  = fault.valid & log_en;
    wire logic merge = take & (|hit);
    assign free = ~busy;
    assign load = (take & ~merge)
                ? (free & (~free + LOG_N'(1))) : '0;
    wire logic drop  = take & ~merge & ~(|free);

    // Slots plus their write-one-to-clear strobes
    for (genvar i = 0; i < LOG_N; i++) begin : g_slot
        assign hit[i] = busy[i]
                      & (entry[i].source_id == fault.source_id);
        assign clear_req[i] = wr_log
                            & (log_idx == LOG_IW'(i))
                            & (log_word == FLAG_WORD)
                            & pwdata[FLAG_POS];
        fevt_log_slot #(
            .HAS_DEV_TLB (HAS_DEV_TLB),
            .HAS_PASID   (HAS_PASID)
        ) u_slot (
            .pclk      (pclk),
            .presetn   (presetn),
            .load      (load[i]),
            .fault     (fault),
            .clear_req (clear_req[i]),
            .entry     (entry[i]),
            .logged    (logged[i]),
            .busy      (busy[i])
        );
    end

    // Faults the log could not hold; set wins over software clear
    wire logic ovf_clr = wr_stat & pwdata[STAT_OVF_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow <= 1'b0;
        end else begin
            overflow <= drop | (overflow & ~ovf_clr);
        end
    end

    // One-cycle reports of merged and dropped faults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_merged  <= 1'b0;
            fault_dropped <= 1'b0;
        end else begin
            fault_merged  <= merge;
            fault_dropped <= drop;
        end
    end

    // A record landing while nothing was logged is a new condition;
    // further records just ride on the message already pending
    wire logic any_busy   = |busy;
    wire logic any_logged = |logged;
    wire logic rec_done   = |(busy & ~logged);
    wire logic new_cond   = rec_done & ~any_logged;
    wire logic sent       = msg_valid & msg_ready;
    wire logic next_pending = new_cond
                            | (pending & ~sent & any_busy);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else begin
            pending <= next_pending;
        end
    end

    // Message held back while masked, released on unmask
    assign msg_valid = pending & ~msg_mask;
    assign msg.addr  = {irq_addr_high, irq_addr_low};
    assign msg.data  = {16'h0, msg_data};

    // Read values
    wire logic [31:0] cap_val =
        (32'(LOG_N - 1) << CAP_CNT_LSB)
        | (32'(OFF_LOG_BASE >> 4) << CAP_OFF_LSB);
    wire logic [31:0] ctrl_val =
        (32'(msg_mask) << CTRL_MASK_BIT)
        | (32'(log_en) << CTRL_LOG_BIT);
    wire logic [31:0] stat_val =
        (32'(pending) << STAT_PEND_BIT)
        | (32'(overflow) << STAT_OVF_BIT)
        | (32'(any_logged) << STAT_LOG_BIT);
    wire logic [127:0] log_rec = entry[log_idx];
    wire logic [31:0]  log_val = log_rec[{log_word, 5'h0} +: 32];

    // Read select; unmapped addresses read zero
    wire logic [31:0] rd_mux =
          ({32{sel_cap}}  & cap_val)
        | ({32{sel_ctrl}} & ctrl_val)
        | ({32{sel_data}} & {16'h0, msg_data})
        | ({32{sel_lo}}   & irq_addr_low)
        | ({32{sel_hi}}   & irq_addr_high)
        | ({32{sel_stat}} & stat_val)
        | ({32{sel_log}}  & log_val);

    // Read data latched in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (apb_setup) begin
            prdata <= rd_mux;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    low_write_a: assert property (
        wr_lo |=> irq_addr_low == {$past(pwdata[31:2]), 2'h0})
        else $error("lower address not written");
    low_rsvd_a: assert property (
        apb_setup && sel_lo |=> prdata[1:0] == 2'h0)
        else $error("lower address bits 1:0 read nonzero");
    high_write_a: assert property (
        wr_hi && HAS_EXT_IRQ |=> irq_addr_high == $past(pwdata))
        else $error("upper address not written");
    high_rsvd_a: assert property (
        !HAS_EXT_IRQ |-> irq_addr_high == 32'h0)
        else $error("upper address nonzero without support");
    no_log_off_a: assert property (
        !log_en |-> load == '0 && !merge)
        else $error("capture while logging disabled");
    merge_hold_a: assert property (
        merge |-> load == '0 ##1 fault_merged)
        else $error("same-source fault took a new entry");
    one_load_a: assert property (
        $onehot0(load) and (load & busy) == '0)
        else $error("capture into a busy or multiple entry");
    flag_clear_a: assert property (
        clear_req != '0 && !rec_done |=> (logged & $past(clear_req)) == '0)
        else $error("write one did not clear the flag");
    mask_hold_a: assert property (
        msg_mask |-> !msg_valid)
        else $error("message sent while masked");
    msg_raise_a: assert property (
        new_cond && !msg_mask ##1 !msg_mask |-> msg_valid
            && msg.addr == {irq_addr_high, irq_addr_low})
        else $error("unmasked fault gave no message");
    cap_geom_a: assert property (
        apb_setup && sel_cap |=> prdata[7:0] == 8'(LOG_N - 1))
        else $error("capability count wrong");
    bad_addr_a: assert property (
        apb_acc && !mapped |-> pslverr)
        else $error("unmapped access not refused");

    capture_c: cover property (load != '0 ##2 any_logged);
    merge_c: cover property (merge);
    send_c: cover property (msg_valid && msg_ready);
    clear_c: cover property (clear_req != '0 ##1 !any_logged);
    drop_c: cover property (drop);
endmodule // fevt_regs

// ==== tb/fevt_msg_sink.sv ====
module fevt_msg_sink import fevt_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       msg_valid,
    input  wire fevt_msg_s  msg,
    input  wire logic [1:0] stall,
    output logic            msg_ready,
    output logic [63:0]     last_addr,
    output int              n_msgs
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] wait_cnt;

    // Ready is held back a few cycles, as a busy fabric would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 2'h0;
            msg_ready <= 1'b0;
            last_addr <= 64'h0;
            n_msgs <= 0;
        end else if (msg_valid && msg_ready) begin
            last_addr <= msg.addr;
            n_msgs <= n_msgs + 1;
            msg_ready <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (msg_valid) begin
            if (wait_cnt >= stall) msg_ready <= 1'b1;
            else wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule // fevt_msg_sink

// ==== tb/tb.sv ====
module tb import fevt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata, prdata_min, rdat, rdat2;
    logic              pready, pslverr, pslverr_min, rerr;
    logic              fault_merged, fault_dropped, msg_valid, msg_ready;
    fevt_fault_s       fault = '0;
    fevt_msg_s         msg;
    logic [1:0]        stall = 2'h0;
    logic [63:0]       last_addr;
    logic [31:0]       seed = 32'h58;
    int                n_msgs;
    int                err_count = 0;
    int                n_checks = 0;

    // Free-running bus clock
    always #12.5 pclk = ~pclk;

    fevt_regs u_fevt_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault(fault),
        .fault_merged(fault_merged), .fault_dropped(fault_dropped),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg));
    // Minimal build on the same bus: no extended mode, TLB or PASID
    fevt_regs #(.HAS_EXT_IRQ(1'b0), .HAS_DEV_TLB(1'b0), .HAS_PASID(1'b0))
        u_fevt_regs_min (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_min), .pready(), .pslverr(pslverr_min), .fault(fault),
        .fault_merged(), .fault_dropped(), .msg_valid(), .msg_ready(1'b1),
        .msg());
    fevt_msg_sink u_fevt_msg_sink (.pclk(pclk), .presetn(presetn),
        .msg_valid(msg_valid), .msg(msg), .stall(stall),
        .msg_ready(msg_ready), .last_addr(last_addr), .n_msgs(n_msgs));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic fevt_fault_s rnd_fault(logic [15:0] src);
        logic [63:0] r;
        r = {rnd(), rnd()};
        return {1'b1, src, r[33:0]};
    endfunction

    // Upper entry word; reduced build keeps only flag, type and reason
    function automatic logic [31:0] exp_w3(fevt_fault_s f, bit full);
        if (full) return {1'b1, f.req_read, f.addr_kind, f.pasid_value,
                          f.reason_code};
        return {1'b1, f.req_read, 22'h0, f.reason_code};
    endfunction

    function automatic logic [31:0] exp_w2(fevt_fault_s f, bit full);
        if (full) return {f.prefix_present, f.run_permission_asked,
                          f.supervisor_asked, 13'h0, f.source_id};
        return {16'h0, f.source_id};
    endfunction

    function automatic logic [11:0] ea(int n, int w);
        return OFF_LOG_BASE + 12'(n * LOG_STRIDE) + 12'(4 * w);
    endfunction

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; results land in rdat, rdat2 and rerr
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) check("pready", 32'h0, 32'h1);
        rdat = prdata;
        rdat2 = prdata_min;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Fault is a one-cycle pulse; flags are read once that edge settles
    task automatic inject(fevt_fault_s f);
        @(posedge pclk);
        fault <= f;
        @(posedge pclk);
        fault <= '0;
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #(25 * 20000);
        err_count++;
        report_and_stop();
    end

    initial begin
        fevt_fault_s f[LOG_N];
        fevt_fault_s g;
        logic [31:0] lo, hi;
        int n;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_ADDR_LO, 32'h0);
        check("addr_lo reset", rdat, 32'h0);
        apb(1'b0, OFF_ADDR_HI, 32'h0);
        check("addr_hi reset", rdat, 32'h0);
        apb(1'b0, OFF_CAP, 32'h0);
        check("cap", {rdat[25:16], rdat[7:0]},
              {10'(OFF_LOG_BASE >> 4), 8'(LOG_N - 1)});
        apb(1'b0, 12'h0fc, 32'h0);
        check("unmapped err", rerr, 32'h1);
        $display("test reset done");
        // First pass drives all ones to expose the low reserved bits
        for (int i = 0; i < 4; i++) begin
            lo = (i == 0) ? 32'hffff_ffff : rnd();
            hi = rnd();
            apb(1'b1, OFF_ADDR_LO, lo);
            apb(1'b1, OFF_ADDR_HI, hi);
            apb(1'b0, OFF_ADDR_LO, 32'h0);
            check("addr_lo", rdat, {lo[31:2], 2'b00});
            apb(1'b0, OFF_ADDR_HI, 32'h0);
            check("addr_hi", rdat, hi);
            check("addr_hi min", rdat2, 32'h0);
        end
        $display("test address done");
        inject(rnd_fault(16'h0100));
        apb(1'b0, ea(0, 3), 32'h0);
        check("logging off", rdat, 32'h0);
        stall <= 2'(rnd());
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        for (int e = 0; e < LOG_N; e++) begin
            f[e] = rnd_fault(16'h0200 + 16'(e));
            inject(f[e]);
            check("merged", fault_merged, 32'h0);
            apb(1'b0, ea(e, 3), 32'h0);
            check("w3", rdat, exp_w3(f[e], 1));
            check("w3 min", rdat2, exp_w3(f[e], 0));
            apb(1'b0, ea(e, 2), 32'h0);
            check("w2", rdat, exp_w2(f[e], 1));
            check("w2 min", rdat2, exp_w2(f[e], 0));
        end
        n = 0;
        while (n_msgs < 1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        check("msg count", n_msgs, 32'h1);
        check("msg addr lo", last_addr[31:0], {lo[31:2], 2'b00});
        check("msg addr hi", last_addr[63:32], hi);
        $display("test logging done");
        g = rnd_fault(f[1].source_id);
        inject(g);
        check("merged", fault_merged, 32'h1);
        apb(1'b1, ea(1, 3), 32'h7fff_ffff);
        apb(1'b1, ea(1, 2), 32'hffff_ffff);
        apb(1'b0, ea(1, 3), 32'h0);
        check("w3 kept", rdat, exp_w3(f[1], 1));
        apb(1'b0, ea(1, 2), 32'h0);
        check("w2 kept", rdat, exp_w2(f[1], 1));
        apb(1'b1, ea(1, 3), 32'h8000_0000);
        apb(1'b0, ea(1, 3), 32'h0);
        check("flag clear", rdat[31], 32'h0);
        apb(1'b0, ea(2, 3), 32'h0);
        check("other kept", rdat, exp_w3(f[2], 1));
        $display("test merge and clear done");
        // Freed slot is reused; with every slot busy the next fault drops
        g = rnd_fault(16'h0300);
        inject(g);
        check("reuse merged", fault_merged, 32'h0);
        check("reuse dropped", fault_dropped, 32'h0);
        apb(1'b0, ea(1, 3), 32'h0);
        check("reuse w3", rdat, exp_w3(g, 1));
        inject(rnd_fault(16'h0301));
        check("full dropped", fault_dropped, 32'h1);
        apb(1'b0, OFF_STAT, 32'h0);
        check("overflow", rdat[STAT_OVF_BIT], 32'h1);
        apb(1'b0, ea(0, 3), 32'h0);
        check("full kept", rdat, exp_w3(f[0], 1));
        $display("test reuse and overflow done");
        report_and_stop();
    end
endmodule // tb
